/* File: rtl/tmr_params.svh */
// Register addresses, reset values and bus constants of the temperature monitor port.
`ifndef TMR_PARAMS_SVH
`define TMR_PARAMS_SVH

// Read addresses.
`define TMR_RD_LOCAL_VAL 8'h00
`define TMR_RD_REM_VAL_HI 8'h01
`define TMR_RD_STATUS 8'h02
`define TMR_RD_CFG 8'h03
`define TMR_RD_RATE 8'h04
`define TMR_RD_LHI 8'h05
`define TMR_RD_LLO 8'h06
`define TMR_RD_RHI_U 8'h07
`define TMR_RD_RLO_U 8'h08
`define TMR_RD_REM_VAL_LO 8'h10

// Write addresses of registers whose read address differs.
`define TMR_WR_CFG 8'h09
`define TMR_WR_RATE 8'h0a
`define TMR_WR_LHI 8'h0b
`define TMR_WR_LLO 8'h0c
`define TMR_WR_RHI_U 8'h0d
`define TMR_WR_RLO_U 8'h0e
`define TMR_WR_ONE_SHOT 8'h0f

// Registers that share one address for read and write.
`define TMR_RW_ROFS_U 8'h11
`define TMR_RW_ROFS_L 8'h12
`define TMR_RW_RHI_L 8'h13
`define TMR_RW_RLO_L 8'h14
`define TMR_RW_RCRIT 8'h19
`define TMR_RW_LCRIT 8'h20
`define TMR_RW_HYST 8'h21

// Power-on values, and the value read at an unmapped address.
`define TMR_RST_ZERO 8'h00
`define TMR_RST_RATE 8'h08
`define TMR_RST_HI_LIMIT 8'h55
`define TMR_RST_RCRIT 8'h6c
`define TMR_RST_LCRIT 8'h55
`define TMR_RST_HYST 8'h0a
`define TMR_UNMAPPED_READ 8'h00

// Own bus address; the value is arbitrary.
`define TMR_SLAVE_ADDR 7'h2a
// Bits per byte on the wire.
`define TMR_BYTE_BITS 4'h8

`endif

/* File: rtl/tmr_pkg.sv */
// Types shared by the temperature monitor register port.
package tmr_pkg;
  typedef logic [7:0] tmr_byte_t;
  typedef enum logic [2:0] {
    st_idle,
    st_addr,
    st_addr_ack,
    st_wr,
    st_wr_ack,
    st_rd,
    st_rd_ack
  } tmr_state_t;
endpackage

/* File: rtl/tmr_link_if.sv */
// Byte link between the serial engine and the register file.
`timescale 1ns/1ns
interface tmr_link_if;
  import tmr_pkg::*;
  logic wr_stb;
  logic wr_first;
  tmr_byte_t wr_byte;
  logic rd_stb;
  tmr_byte_t rd_byte;
  logic sda_drive;

  modport slv (
    output wr_stb,
    output wr_first,
    output wr_byte,
    output rd_stb,
    output sda_drive,
    input rd_byte
  );
  modport regs (
    input wr_stb,
    input wr_first,
    input wr_byte,
    input rd_stb,
    input sda_drive,
    output rd_byte
  );
endinterface

/* File: rtl/tmr_serial_slave.sv */
// Two-wire serial slave engine: pin filtering, framing, address match and bit shifting.
`timescale 1ns/1ns
`include "tmr_params.svh"
module tmr_serial_slave
  import tmr_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = `TMR_SLAVE_ADDR
)
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_b,
  // Raw pin levels, bit 0 clock line, bit 1 data line.
  input wire logic [1:0] pins_in,
  // Link to the register file.
  tmr_link_if.slv lk
);
  logic [1:0] s1_q, s2_q, s3_q, filt_q, filt_d;
  tmr_state_t st_q, st_d;
  tmr_byte_t sh_q, sh_d, wrb_q, wrb_d;
  logic [3:0] cnt_q, cnt_d;
  logic [1:0] nbyte_q, nbyte_d;
  logic rw_q, rw_d, drv_q, drv_d, wstb_q, wstb_d, first_q, first_d, rstb_q, rstb_d;
  logic scl_rise, scl_fall, start_ev, stop_ev;

  // A level is accepted only when the second and third stages agree, which rejects glitches.
  always_comb
  begin
    filt_d = filt_q;
    for (int i = 0; i < 2; i++)
    begin
      if (s2_q[i] == s3_q[i])
        filt_d[i] = s3_q[i];
    end
  end

  // Bus events from the filtered levels.
  assign scl_rise = filt_d[0] & ~filt_q[0];
  assign scl_fall = ~filt_d[0] & filt_q[0];
  assign start_ev = filt_q[0] & filt_d[0] & filt_q[1] & ~filt_d[1];
  assign stop_ev = filt_q[0] & filt_d[0] & ~filt_q[1] & filt_d[1];

  // Framing state machine; a start or stop always wins over the byte flow.
  always_comb
  begin
    st_d = st_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    nbyte_d = nbyte_q;
    rw_d = rw_q;
    drv_d = drv_q;
    wrb_d = wrb_q;
    first_d = first_q;
    wstb_d = 1'b0;
    rstb_d = 1'b0;
    if (start_ev)
    begin
      st_d = st_addr;
      cnt_d = 4'h0;
      nbyte_d = 2'h0;
      drv_d = 1'b0;
    end
    else if (stop_ev)
    begin
      st_d = st_idle;
      drv_d = 1'b0;
    end
    else
    begin
      case (st_q)
        st_addr, st_wr:
        begin
          if (scl_rise)
          begin
            sh_d = {sh_q[6:0], filt_q[1]};
            cnt_d = cnt_q + 4'h1;
          end
          else if (scl_fall && cnt_q == `TMR_BYTE_BITS)
          begin
            if (st_q == st_addr && sh_q[7:1] != SLAVE_ADDR)
              st_d = st_idle;
            else if (st_q == st_addr)
            begin
              drv_d = 1'b1;
              rw_d = sh_q[0];
              rstb_d = sh_q[0];
              st_d = st_addr_ack;
            end
            else if (nbyte_q != 2'h2)
            begin
              drv_d = 1'b1;
              wstb_d = 1'b1;
              first_d = (nbyte_q == 2'h0);
              wrb_d = sh_q;
              nbyte_d = nbyte_q + 2'h1;
              st_d = st_wr_ack;
            end
            else
              st_d = st_idle;
          end
        end
        st_addr_ack, st_wr_ack:
        begin
          if (scl_fall)
          begin
            cnt_d = 4'h0;
            if (st_q == st_addr_ack && rw_q)
            begin
              sh_d = lk.rd_byte;
              drv_d = ~lk.rd_byte[7];
              st_d = st_rd;
            end
            else
            begin
              drv_d = 1'b0;
              st_d = st_wr;
            end
          end
        end
        st_rd:
        begin
          if (scl_rise)
            cnt_d = cnt_q + 4'h1;
          else if (scl_fall && cnt_q == `TMR_BYTE_BITS)
          begin
            drv_d = 1'b0;
            st_d = st_rd_ack;
          end
          else if (scl_fall)
          begin
            drv_d = ~sh_q[6];
            sh_d = {sh_q[6:0], 1'b0};
          end
        end
        st_rd_ack:
        begin
          if (scl_rise)
            st_d = st_idle;
        end
        default:
          st_d = st_idle;
      endcase
    end
  end

  // State registers.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1_q <= 2'h3;
      s2_q <= 2'h3;
      s3_q <= 2'h3;
      filt_q <= 2'h3;
      st_q <= st_idle;
      sh_q <= 8'h00;
      cnt_q <= 4'h0;
      nbyte_q <= 2'h0;
      rw_q <= 1'b0;
      drv_q <= 1'b0;
      wrb_q <= 8'h00;
      first_q <= 1'b0;
      wstb_q <= 1'b0;
      rstb_q <= 1'b0;
    end
    else
    begin
      s1_q <= pins_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
      st_q <= st_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      nbyte_q <= nbyte_d;
      rw_q <= rw_d;
      drv_q <= drv_d;
      wrb_q <= wrb_d;
      first_q <= first_d;
      wstb_q <= wstb_d;
      rstb_q <= rstb_d;
    end
  end

  assign lk.wr_stb = wstb_q;
  assign lk.wr_first = first_q;
  assign lk.wr_byte = wrb_q;
  assign lk.rd_stb = rstb_q;
  assign lk.sda_drive = drv_q;
endmodule

/* File: rtl/tmr_smbus_port.sv */
// Serial register-access port of a dual-channel temperature monitor.
`timescale 1ns/1ns
`include "tmr_params.svh"
// A write carries a register address and at most one data byte; a read returns one byte.
// There is no clock stretching: the read byte is fetched a whole bit time before it is
// needed, well inside one clock low period.
module tmr_smbus_port
  import tmr_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = `TMR_SLAVE_ADDR
)
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_b,
  // Serial pins; the data line is open drain.
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out_q,
  output logic sda_oe_q,
  // Results from the measurement engine.
  input wire logic meas_stb,
  input wire tmr_byte_t local_meas,
  input wire tmr_byte_t remote_meas_upper,
  input wire tmr_byte_t remote_meas_lower,
  input wire tmr_byte_t status_in,
  // Programmed settings toward the measurement and alarm logic.
  output tmr_byte_t config_control_q,
  output tmr_byte_t conversion_rate_select_q,
  output tmr_byte_t local_high_limit_q,
  output tmr_byte_t local_low_limit_q,
  output tmr_byte_t remote_high_limit_upper_q,
  output tmr_byte_t remote_high_limit_lower_q,
  output tmr_byte_t remote_low_limit_upper_q,
  output tmr_byte_t remote_low_limit_lower_q,
  output tmr_byte_t remote_offset_upper_q,
  output tmr_byte_t remote_offset_lower_q,
  output tmr_byte_t remote_critical_trip_limit_q,
  output tmr_byte_t local_critical_trip_limit_q,
  output tmr_byte_t critical_trip_hysteresis_q,
  // One-cycle request for a single conversion.
  output logic single_conversion_trigger_q,
  // Visible pointer and freeze state.
  output tmr_byte_t register_pointer_q,
  output logic remote_upper_frozen_q
);
  // Reserved bus addresses cannot be served.
  // Addresses below 0x08 and above 0x77 are held back by the bus protocol.
  if (SLAVE_ADDR < 7'h08 || SLAVE_ADDR > 7'h77)
  begin : g_bad_addr
    $error("SLAVE_ADDR lies in a reserved range");
  end

  // Byte link between the serial engine and the register file.
  tmr_link_if lk ();

  // Serial engine. It hands over one byte at a time and queues nothing,
  // so the register file must take each strobe in the cycle it stands.
  tmr_serial_slave #(
    .SLAVE_ADDR(SLAVE_ADDR)
  ) u_slave (
    .mclk(mclk),
    .rst_b(rst_b),
    .pins_in({sda_in, scl_in}),
    .lk(lk)
  );

  // Next values of the writable registers.
  tmr_byte_t ptr_d, cfg_d, rate_d, lhi_d, llo_d, rhiu_d, rhil_d, rlou_d, rlol_d;
  tmr_byte_t rofsu_d, rofsl_d, rcrit_d, lcrit_d, hyst_d;
  logic trig_d;
  // Measured values and status.
  tmr_byte_t local_val_q, local_val_d, rem_hi_q, rem_hi_d, rem_lo_q, rem_lo_d;
  tmr_byte_t status_q, status_d;
  // Freeze flag and the byte held ready for a read.
  logic frozen_d;
  tmr_byte_t rd_byte_q, rd_byte_d;
  // Pin stage.
  logic sda_oe_d;

  // Read decode; the read address of a split register never aliases its write address.
  function automatic tmr_byte_t reg_read(input tmr_byte_t addr);
    tmr_byte_t v;
    v = `TMR_UNMAPPED_READ;
    // Measured values and status are reachable only at their read addresses.
    case (addr)
      `TMR_RD_LOCAL_VAL: v = local_val_q;
      `TMR_RD_REM_VAL_HI: v = rem_hi_q;
      `TMR_RD_STATUS: v = status_q;
      `TMR_RD_CFG: v = config_control_q;
      `TMR_RD_RATE: v = conversion_rate_select_q;
      `TMR_RD_LHI: v = local_high_limit_q;
      `TMR_RD_LLO: v = local_low_limit_q;
      `TMR_RD_RHI_U: v = remote_high_limit_upper_q;
      `TMR_RD_RLO_U: v = remote_low_limit_upper_q;
      `TMR_RD_REM_VAL_LO: v = rem_lo_q;
      `TMR_RW_ROFS_U: v = remote_offset_upper_q;
      `TMR_RW_ROFS_L: v = remote_offset_lower_q;
      `TMR_RW_RHI_L: v = remote_high_limit_lower_q;
      `TMR_RW_RLO_L: v = remote_low_limit_lower_q;
      `TMR_RW_RCRIT: v = remote_critical_trip_limit_q;
      `TMR_RW_LCRIT: v = local_critical_trip_limit_q;
      `TMR_RW_HYST: v = critical_trip_hysteresis_q;
      default: v = `TMR_UNMAPPED_READ;
    endcase
    return v;
  endfunction

  // Pointer and writable registers. The first byte of a write only moves the pointer,
  // so the data byte always lands where the address byte just pointed.
  always_comb
  begin
    // Every register but the one-shot trigger holds its value unless a write strobe selects it; the trigger clears.
    ptr_d = register_pointer_q;
    cfg_d = config_control_q;
    rate_d = conversion_rate_select_q;
    lhi_d = local_high_limit_q;
    llo_d = local_low_limit_q;
    rhiu_d = remote_high_limit_upper_q;
    rhil_d = remote_high_limit_lower_q;
    rlou_d = remote_low_limit_upper_q;
    rlol_d = remote_low_limit_lower_q;
    rofsu_d = remote_offset_upper_q;
    rofsl_d = remote_offset_lower_q;
    rcrit_d = remote_critical_trip_limit_q;
    lcrit_d = local_critical_trip_limit_q;
    hyst_d = critical_trip_hysteresis_q;
    trig_d = 1'b0;
    // Read-only and unlisted pointer values fall through to the default arm.
    if (lk.wr_stb && lk.wr_first)
      ptr_d = lk.wr_byte;
    else if (lk.wr_stb)
    begin
      case (register_pointer_q)
        `TMR_WR_CFG: cfg_d = lk.wr_byte;
        `TMR_WR_RATE: rate_d = lk.wr_byte;
        `TMR_WR_LHI: lhi_d = lk.wr_byte;
        `TMR_WR_LLO: llo_d = lk.wr_byte;
        `TMR_WR_RHI_U: rhiu_d = lk.wr_byte;
        `TMR_WR_RLO_U: rlou_d = lk.wr_byte;
        // The one-shot address stores nothing; it only raises a pulse.
        `TMR_WR_ONE_SHOT: trig_d = 1'b1;
        `TMR_RW_ROFS_U: rofsu_d = lk.wr_byte;
        `TMR_RW_ROFS_L: rofsl_d = lk.wr_byte;
        `TMR_RW_RHI_L: rhil_d = lk.wr_byte;
        `TMR_RW_RLO_L: rlol_d = lk.wr_byte;
        `TMR_RW_RCRIT: rcrit_d = lk.wr_byte;
        `TMR_RW_LCRIT: lcrit_d = lk.wr_byte;
        `TMR_RW_HYST: hyst_d = lk.wr_byte;
        default: ptr_d = register_pointer_q;
      endcase
    end
  end

  // Register storage; the pointer is only ever changed by a write, never by a read.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      register_pointer_q <= `TMR_RST_ZERO;
      config_control_q <= `TMR_RST_ZERO;
      conversion_rate_select_q <= `TMR_RST_RATE;
      local_high_limit_q <= `TMR_RST_HI_LIMIT;
      local_low_limit_q <= `TMR_RST_ZERO;
      remote_high_limit_upper_q <= `TMR_RST_HI_LIMIT;
      remote_high_limit_lower_q <= `TMR_RST_ZERO;
      remote_low_limit_upper_q <= `TMR_RST_ZERO;
      remote_low_limit_lower_q <= `TMR_RST_ZERO;
      remote_offset_upper_q <= `TMR_RST_ZERO;
      remote_offset_lower_q <= `TMR_RST_ZERO;
      // Critical-trip limits and hysteresis take their chosen power-on values.
      remote_critical_trip_limit_q <= `TMR_RST_RCRIT;
      local_critical_trip_limit_q <= `TMR_RST_LCRIT;
      critical_trip_hysteresis_q <= `TMR_RST_HYST;
      single_conversion_trigger_q <= 1'b0;
    end
    else
    begin
      // The pointer moves only on the first byte of a write.
      register_pointer_q <= ptr_d;
      config_control_q <= cfg_d;
      conversion_rate_select_q <= rate_d;
      local_high_limit_q <= lhi_d;
      local_low_limit_q <= llo_d;
      remote_high_limit_upper_q <= rhiu_d;
      remote_high_limit_lower_q <= rhil_d;
      remote_low_limit_upper_q <= rlou_d;
      remote_low_limit_lower_q <= rlol_d;
      remote_offset_upper_q <= rofsu_d;
      remote_offset_lower_q <= rofsl_d;
      remote_critical_trip_limit_q <= rcrit_d;
      local_critical_trip_limit_q <= lcrit_d;
      critical_trip_hysteresis_q <= hyst_d;
      single_conversion_trigger_q <= trig_d;
    end
  end

  // Measured values and the upper-byte freeze. Reading the lower byte first pins the
  // upper byte, so a conversion landing between the two reads cannot tear the result.
  always_comb
  begin
    // Hold by default; results and reads below override.
    local_val_d = local_val_q;
    rem_hi_d = rem_hi_q;
    rem_lo_d = rem_lo_q;
    status_d = status_q;
    frozen_d = remote_upper_frozen_q;
    rd_byte_d = rd_byte_q;
    // A new result replaces every value except a frozen upper byte.
    if (meas_stb)
    begin
      local_val_d = local_meas;
      rem_lo_d = remote_meas_lower;
      status_d = status_in;
      if (!remote_upper_frozen_q)
        rem_hi_d = remote_meas_upper;
    end
    // One byte is captured per read; the pointer itself is left alone.
    if (lk.rd_stb)
    begin
      rd_byte_d = reg_read(register_pointer_q);
      if (register_pointer_q == `TMR_RD_REM_VAL_LO)
        frozen_d = 1'b1;
      else if (register_pointer_q == `TMR_RD_REM_VAL_HI)
        frozen_d = 1'b0;
    end
  end

  // Measured-value storage, all zero after reset.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // Values and status read zero until the first conversion lands.
      local_val_q <= `TMR_RST_ZERO;
      rem_hi_q <= `TMR_RST_ZERO;
      rem_lo_q <= `TMR_RST_ZERO;
      status_q <= `TMR_RST_ZERO;
      remote_upper_frozen_q <= 1'b0;
      rd_byte_q <= `TMR_RST_ZERO;
    end
    else
    begin
      local_val_q <= local_val_d;
      rem_hi_q <= rem_hi_d;
      rem_lo_q <= rem_lo_d;
      status_q <= status_d;
      // While the freeze is clear a conversion may refresh the upper byte.
      remote_upper_frozen_q <= frozen_d;
      rd_byte_q <= rd_byte_d;
    end
  end

  // Byte offered to the serial engine for the next read.
  assign lk.rd_byte = rd_byte_q;

  // Pin stage. Retiming the enable costs one clock, far below a bit time of the bus.
  // A start or stop clears the drive, so the enable falls two clocks after the event and a cut frame never holds the line.
  always_comb
  begin
    sda_oe_d = lk.sda_drive;
  end

  // The data line is only ever pulled low, so its output level stays zero.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sda_oe_q <= 1'b0;
      sda_out_q <= 1'b0;
    end
    else
    begin
      sda_oe_q <= sda_oe_d;
      sda_out_q <= 1'b0;
    end
  end
endmodule

/* File: testbench/tmr_smbus_chk.sv */
// Concurrent checks on the ports of the temperature monitor register port.
`timescale 1ns/1ns
module tmr_smbus_chk
  import tmr_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_b,
  // Serial pins.
  input wire logic scl_in,
  input wire logic sda_oe_q,
  // Settings and state that are watched.
  input wire tmr_byte_t config_control_q,
  input wire tmr_byte_t conversion_rate_select_q,
  input wire tmr_byte_t local_high_limit_q,
  input wire tmr_byte_t remote_high_limit_upper_q,
  input wire tmr_byte_t remote_offset_upper_q,
  input wire tmr_byte_t remote_critical_trip_limit_q,
  input wire logic single_conversion_trigger_q,
  input wire tmr_byte_t register_pointer_q,
  input wire logic remote_upper_frozen_q
);
  // All checks live in the one clock domain and pause during reset.
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  // Power-on contents must already stand at the first edge after release.
  rst_vals_a: assert property ($rose(rst_b) |-> config_control_q == 8'h00
    && conversion_rate_select_q == 8'h08 && local_high_limit_q == 8'h55
    && remote_high_limit_upper_q == 8'h55 && remote_critical_trip_limit_q == 8'h6c)
    else $error("power-on contents wrong");
  // A setting only moves while the pointer holds its write address.
  cfg_write_a: assert property ($changed(config_control_q) |-> register_pointer_q == 8'h09)
    else $error("configuration changed at wrong pointer");
  rate_write_a: assert property ($changed(conversion_rate_select_q)
    |-> register_pointer_q == 8'h0a) else $error("rate changed at wrong pointer");
  offset_write_a: assert property ($changed(remote_offset_upper_q)
    |-> register_pointer_q == 8'h11) else $error("offset changed at wrong pointer");
  trig_pulse_a: assert property (single_conversion_trigger_q
    |-> register_pointer_q == 8'h0f ##1 !single_conversion_trigger_q)
    else $error("one-shot pulse wrong");
  // The pointer is only reloaded while the clock line is low.
  ptr_hold_a: assert property (scl_in |=> $stable(register_pointer_q))
    else $error("pointer moved with clock high");
  // The device changes the data line only while the clock line is low.
  oe_rise_a: assert property ($rose(sda_oe_q) |-> !scl_in)
    else $error("data drive began with clock high");
  oe_fall_a: assert property ($fell(sda_oe_q) |-> !scl_in)
    else $error("data drive ended with clock high");
  frz_set_a: assert property ($rose(remote_upper_frozen_q) |-> register_pointer_q == 8'h10)
    else $error("freeze set at wrong pointer");
  frz_clr_a: assert property ($fell(remote_upper_frozen_q) |-> register_pointer_q == 8'h01)
    else $error("freeze cleared at wrong pointer");
endmodule

bind tmr_smbus_port tmr_smbus_chk chk_u (.mclk, .rst_b, .scl_in, .sda_oe_q,
  .config_control_q, .conversion_rate_select_q, .local_high_limit_q,
  .remote_high_limit_upper_q, .remote_offset_upper_q, .remote_critical_trip_limit_q,
  .single_conversion_trigger_q, .register_pointer_q, .remote_upper_frozen_q);

/* File: testbench/tmr_bus_master.sv */
// Behavioural two-wire bus master that talks to the register port.
`timescale 1ns/1ns
module tmr_bus_master
(
  // Clock.
  input wire logic mclk,
  // Bus lines; the data line is open drain with a pull-up.
  input wire logic sda,
  output logic scl,
  output logic sda_m
);
  // Quarter bit of 33 cycles keeps the bus clock under 400 kHz and each half above 1.3 us.
  localparam int QTR = 33;

  // Bus idles released, and the clock stands still between frames.
  initial {scl, sda_m} = 2'b11;

  // Every change lands after a falling mclk edge, away from sampling.
  task automatic st(input logic [1:0] v);
    {scl, sda_m} = v;
    repeat (QTR) @(negedge mclk);
  endtask
  // Start, also used as a repeated start.
  task automatic start();
    st({scl, 1'b1});
    st(2'b11);
    st(2'b10);
    st(2'b00);
  endtask
  // Stop: data taken low with clock low, then released while clock is high.
  task automatic stop();
    st(2'b00);
    st(2'b10);
    st(2'b11);
  endtask
  // One bit; data only changes while the clock is low.
  task automatic bit_io(input logic b, output logic r);
    st({1'b0, b});
    st({1'b1, b});
    r = sda;
    st({1'b1, b});
    st({1'b0, b});
  endtask
  // Eight bits MSB first, then the ninth bit with the data line released.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // Whole transaction; a read returns one byte and ends with not-acknowledge.
  task automatic xact(input logic rw, input logic [6:0] a, input logic [7:0] p,
    input logic [7:0] d, input logic two, output logic [7:0] v, output logic ok);
    logic k;
    start();
    xfer({a, rw}, v, ok);
    xfer(rw ? 8'hff : p, v, k);
    ok &= rw | k;
    if (!rw && two)
      xfer(d, v, k);
    ok &= rw | k;
    stop();
  endtask
endmodule

/* File: testbench/tb_tmr_smbus_port.sv */
// Self-checking bench of the temperature monitor register port.
`timescale 1ns/1ns
`include "tmr_params.svh"
module tb_tmr_smbus_port import tmr_pkg::*;;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic meas_stb = 1'b0;
  tmr_byte_t local_meas = 8'h00;
  tmr_byte_t remote_meas_upper = 8'h00;
  tmr_byte_t remote_meas_lower = 8'h00;
  tmr_byte_t status_in = 8'h00;
  logic scl, sda_m, sda, sda_oe_q, sda_out_q, single_conversion_trigger_q, remote_upper_frozen_q;
  tmr_byte_t config_control_q, conversion_rate_select_q, local_high_limit_q;
  tmr_byte_t local_low_limit_q, remote_high_limit_upper_q, remote_high_limit_lower_q;
  tmr_byte_t remote_low_limit_upper_q, remote_low_limit_lower_q, remote_offset_upper_q;
  tmr_byte_t remote_offset_lower_q, remote_critical_trip_limit_q;
  tmr_byte_t local_critical_trip_limit_q, critical_trip_hysteresis_q, register_pointer_q;
  int failures = 0;
  int compares = 0;
  int trig_n = 0;
  logic [31:0] seed = 32'h2198d65a;
  tmr_byte_t wa [13] = '{8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h11, 8'h12, 8'h13,
    8'h14, 8'h19, 8'h20, 8'h21};
  tmr_byte_t ra [13] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h11, 8'h12, 8'h13,
    8'h14, 8'h19, 8'h20, 8'h21};
  tmr_byte_t wv [13];

  // Free-running clock; the data line is pulled up unless someone sinks it.
  always #10 mclk = ~mclk;
  assign sda = sda_m & (!sda_oe_q | sda_out_q);

  tmr_bus_master mst_u (.mclk, .sda, .scl, .sda_m);

  tmr_smbus_port dut_u (.mclk, .rst_b, .scl_in(scl), .sda_in(sda), .sda_out_q, .sda_oe_q,
    .meas_stb, .local_meas, .remote_meas_upper, .remote_meas_lower, .status_in,
    .config_control_q, .conversion_rate_select_q, .local_high_limit_q, .local_low_limit_q,
    .remote_high_limit_upper_q, .remote_high_limit_lower_q, .remote_low_limit_upper_q,
    .remote_low_limit_lower_q, .remote_offset_upper_q, .remote_offset_lower_q,
    .remote_critical_trip_limit_q, .local_critical_trip_limit_q, .critical_trip_hysteresis_q,
    .single_conversion_trigger_q, .register_pointer_q, .remote_upper_frozen_q);

  // Count one-shot pulses; the old value is read, so no race with the design.
  always @(posedge mclk)
    if (single_conversion_trigger_q === 1'b1)
      trig_n++;

  // Xorshift source; fixed seed keeps every run the same.
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Power-on value of a register, keyed by its read address.
  function automatic tmr_byte_t rst_val(input tmr_byte_t a);
    case (a)
      8'h04: return 8'h08;
      8'h05, 8'h07, 8'h20: return 8'h55;
      8'h19: return 8'h6c;
      8'h21: return 8'h0a;
      default: return 8'h00;
    endcase
  endfunction
  // Setting output that belongs to a read address.
  function automatic tmr_byte_t out_of(input tmr_byte_t a);
    case (a)
      8'h03: return config_control_q;
      8'h04: return conversion_rate_select_q;
      8'h05: return local_high_limit_q;
      8'h06: return local_low_limit_q;
      8'h07: return remote_high_limit_upper_q;
      8'h08: return remote_low_limit_upper_q;
      8'h11: return remote_offset_upper_q;
      8'h12: return remote_offset_lower_q;
      8'h13: return remote_high_limit_lower_q;
      8'h14: return remote_low_limit_lower_q;
      8'h19: return remote_critical_trip_limit_q;
      8'h20: return local_critical_trip_limit_q;
      default: return critical_trip_hysteresis_q;
    endcase
  endfunction

  task automatic chk(input string n, input tmr_byte_t e, input tmr_byte_t s);
    compares++;
    if (s !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // Write of pointer and, if asked, one data byte to the own address.
  task automatic wrb(input tmr_byte_t p, input tmr_byte_t d, input logic two);
    tmr_byte_t v;
    logic ok;
    mst_u.xact(1'b0, `TMR_SLAVE_ADDR, p, d, two, v, ok);
    chk("write ack", 8'h01, {7'h00, ok});
  endtask
  // Single-byte read at the current pointer.
  task automatic rdb(input string n, input tmr_byte_t e);
    tmr_byte_t v;
    logic ok;
    mst_u.xact(1'b1, `TMR_SLAVE_ADDR, 8'h00, 8'h00, 1'b0, v, ok);
    chk("read ack", 8'h01, {7'h00, ok});
    chk(n, e, v);
  endtask
  // New measurement results, one strobe cycle.
  task automatic meas();
    @(negedge mclk);
    {local_meas, remote_meas_upper, remote_meas_lower, status_in} = rnd();
    meas_stb = 1'b1;
    @(negedge mclk);
    meas_stb = 1'b0;
  endtask
  task automatic stop_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Watchdog sized a little above the roughly 91k cycles the sequence needs.
  initial
  begin
    repeat (100000) @(posedge mclk);
    failures++;
    stop_test();
  end

  initial
  begin
    logic ok;
    tmr_byte_t up;
    repeat (10) @(negedge mclk);
    rst_b = 1'b1;
    repeat (4) @(negedge mclk);
    for (int i = 0; i < 13; i++)
      chk("reset value", rst_val(ra[i]), out_of(ra[i]));
    chk("reset pointer", 8'h00, register_pointer_q);
    // Measured values; a write at a read-only address must leave them alone.
    meas();
    wrb(8'h00, 8'h00, 1'b0);
    rdb("local value", local_meas);
    wrb(8'h00, ~local_meas, 1'b1);
    rdb("local value kept", local_meas);
    wrb(8'h02, 8'h00, 1'b0);
    rdb("status", status_in);
    // Lower remote byte first; the upper one must come from the same sample.
    wrb(8'h10, 8'h00, 1'b0);
    rdb("remote lower", remote_meas_lower);
    chk("frozen", 8'h01, {7'h00, remote_upper_frozen_q});
    up = remote_meas_upper;
    meas();
    wrb(8'h01, 8'h00, 1'b0);
    rdb("remote upper held", up);
    meas();
    rdb("remote upper fresh", remote_meas_upper);
    // Every writable register through its write address, all-ones first.
    for (int i = 0; i < 13; i++)
    begin
      wv[i] = (i == 0) ? 8'hff : tmr_byte_t'(rnd());
      wrb(wa[i], wv[i], 1'b1);
      chk("pointer", wa[i], register_pointer_q);
    end
    for (int i = 0; i < 13; i++)
      chk("setting", wv[i], out_of(ra[i]));
    wrb(8'h03, 8'h00, 1'b0);
    rdb("config readback", wv[0]);
    // A foreign bus address is not acknowledged and moves nothing.
    mst_u.xact(1'b0, `TMR_SLAVE_ADDR ^ 7'h01, 8'h05, 8'h00, 1'b0, up, ok);
    chk("foreign ack", 8'h00, {7'h00, ok});
    chk("foreign pointer", 8'h03, register_pointer_q);
    wrb(8'h0f, tmr_byte_t'(rnd()), 1'b1);
    chk("one-shot pulses", 8'h01, tmr_byte_t'(trig_n));
    stop_test();
  end
endmodule
